// >>> verilog/attr_trigger_match.sv
// What this block does
// RL1 - compare stored attributes to bus attributes; result feeds trigger logic as configured
// RL2 - register is debug control index 0x06 from instruction and debug port
// RL3 - register is write-only on both paths; no readback
// RL4 - bit 15 set ignores the direction bit in the compare
// RL5 - bits 14-13 mask matching bits of the size field
// RL6 - bits 12-11 mask matching bits of the transfer-class field
// RL7 - bits 10-8 mask matching bits of the transfer-modifier field
// RL8 - bit 7 compared against bus read/write direction
// RL9 - bits 6-5 compared to bus size: long, byte, word, reserved
// RL10 - bits 4-3 compared to bus class: normal, emulator; 01 reserved
// RL11 - class field also feeds debug memory commands; 01 means external/DMA
// RL12 - bits 2-0 compared to bus modifier; meaning depends on class
// RL13 - modifier codes per class; others reserved
// RL14 - each attribute write also loads the command attribute register
// RL15 - match needs all unmasked bits equal; reset holds supervisor data
// RL16 - direction bit one matches reads, zero matches writes
module attr_trigger_match
   import attr_match_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // register writes
   input wire attr_match_pkg::dbg_write_t i_cpu_wr,
   input wire attr_match_pkg::dbg_write_t i_port_wr,
   // local bus attributes
   input wire logic i_bus_valid,
   input wire attr_match_pkg::bus_attr_t i_bus_attr,
   // trigger definition enable for attribute use
   input wire logic i_trig_attr_enable,
   // results
   output logic o_attr_match,
   output logic o_attr_reserved,
   output logic [7:0] o_cmd_attr,
   output logic o_cmd_ext_dma
);
   import attr_match_pkg::*;

   logic load;
   logic [15:0] load_data;
   attr_trig_t trig;
   logic comb_match;

   attr_write_arbiter u_arb (
      .i_sys_clk(i_sys_clk),
      .i_reset_n(i_reset_n),
      .i_cpu_wr(i_cpu_wr),
      .i_port_wr(i_port_wr),
      .o_load(load),
      .o_data(load_data)
   );

   // write-only: nothing drives a read path from here [RL3]
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         trig <= attr_trig_t'(ATTR_TRIG_RESET); // [RL15]
      end else if (load) begin
         trig <= attr_trig_t'(load_data); // [RL2]
      end
   end

   // masked equality of direction, size, class and modifier [RL4] [RL5] [RL6] [RL7]
   attr_compare u_cmp (
      .i_trig(trig),
      .i_bus(i_bus_attr), // [RL8] [RL9] [RL10] [RL12] [RL16]
      .o_match(comb_match)
   );

   wire next_match = i_trig_attr_enable && i_bus_valid && comb_match; // [RL1] [RL15]
   wire next_reserved = attr_reserved(trig.ref_attr); // [RL13]

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_attr_match <= 1'b0;
         o_attr_reserved <= 1'b0;
         o_cmd_attr <= CMD_ATTR_RESET;
         o_cmd_ext_dma <= 1'b0;
      end else begin
         o_attr_match <= next_match;
         o_attr_reserved <= next_reserved;
         if (load) begin
            // low byte mirrors into command attributes for compatibility [RL14]
            o_cmd_attr <= load_data[7:0];
            o_cmd_ext_dma <= (load_data[4:3] == CLASS_EXT_DMA); // [RL11]
         end
      end
   end

   AST_MATCH_FOLLOWS: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [RL1]
      o_attr_match == $past(next_match))
      else $error("attribute match does not follow bus compare");
   AST_DIR_MASK: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [RL4]
      (trig.direction_mask && i_bus_valid && i_trig_attr_enable
       && ((trig[6:0] ^ i_bus_attr[6:0]) & ~{trig.size_mask, trig.transfer_class_mask,
       trig.transfer_modifier_mask}) == 7'h00) |=> o_attr_match)
      else $error("direction mask ignored");
   AST_DIR_CMP: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [RL8]
      (!trig.direction_mask && trig.ref_attr.dir_read != i_bus_attr.dir_read) |=> !o_attr_match)
      else $error("direction mismatch matched");
   AST_SIZE_CMP: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [RL5]
      (|((trig.ref_attr.width_code ^ i_bus_attr.width_code) & ~trig.size_mask)) |=> !o_attr_match)
      else $error("size mismatch matched");
   AST_CLASS_CMP: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [RL6]
      (|((trig.ref_attr.transfer_class ^ i_bus_attr.transfer_class)
       & ~trig.transfer_class_mask)) |=> !o_attr_match)
      else $error("class mismatch matched");
   AST_MOD_CMP: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [RL7]
      (|((trig.ref_attr.transfer_modifier ^ i_bus_attr.transfer_modifier)
       & ~trig.transfer_modifier_mask)) |=> !o_attr_match)
      else $error("modifier mismatch matched");
   AST_LOAD_CMD: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [RL14]
      load |=> (o_cmd_attr == $past(load_data[7:0]) && trig == $past(load_data)))
      else $error("command attributes not loaded with register");
   AST_WRITE_TWO: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [RL2]
      (i_cpu_wr.valid && i_cpu_wr.index == ATTR_TRIG_INDEX && !i_port_wr.valid)
      |=> ##1 (trig == $past(i_cpu_wr.data, 2)))
      else $error("instruction write did not land in two cycles");
   AST_EXT_DMA: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [RL11]
      o_cmd_ext_dma == (o_cmd_attr[4:3] == CLASS_EXT_DMA))
      else $error("external access flag disagrees with class");
   AST_IDLE_NOMATCH: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // [RL15]
      (!i_bus_valid || !i_trig_attr_enable) |=> !o_attr_match)
      else $error("match without enabled bus cycle");
endmodule

// >>> verilog/attr_match_pkg.sv
package attr_match_pkg;

   // debug control register indices
   localparam logic [4:0] ATTR_TRIG_INDEX = 5'h06;
   localparam logic [4:0] TRIG_DEF_INDEX = 5'h07;

   // field positions of the attribute trigger register
   localparam int DIR_MASK_POS = 15;
   localparam int SIZE_MASK_LSB = 13;
   localparam int CLASS_MASK_LSB = 11;
   localparam int MOD_MASK_LSB = 8;
   localparam int DIR_POS = 7;
   localparam int SIZE_LSB = 5;
   localparam int CLASS_LSB = 3;
   localparam int MOD_LSB = 0;

   // reset values
   localparam logic [15:0] ATTR_TRIG_RESET = 16'h0005;
   localparam logic [7:0] CMD_ATTR_RESET = 8'h05;

   // width codes
   localparam logic [1:0] WIDTH_LONG = 2'h0;
   localparam logic [1:0] WIDTH_BYTE = 2'h1;
   localparam logic [1:0] WIDTH_WORD = 2'h2;

   // transfer classes
   localparam logic [1:0] CLASS_NORMAL = 2'h0;
   localparam logic [1:0] CLASS_EXT_DMA = 2'h1;
   localparam logic [1:0] CLASS_EMULATOR = 2'h2;

   // transfer modifiers
   localparam logic [2:0] MOD_LINE_PUSH = 3'h0;
   localparam logic [2:0] MOD_USER_DATA = 3'h1;
   localparam logic [2:0] MOD_USER_CODE = 3'h2;
   localparam logic [2:0] MOD_SUPER_DATA = 3'h5;
   localparam logic [2:0] MOD_SUPER_CODE = 3'h6;

   // one local bus attribute set
   typedef struct packed {
      logic       dir_read;
      logic [1:0] width_code;
      logic [1:0] transfer_class;
      logic [2:0] transfer_modifier;
   } bus_attr_t;

   // packed stored register
   typedef struct packed {
      logic       direction_mask;
      logic [1:0] size_mask;
      logic [1:0] transfer_class_mask;
      logic [2:0] transfer_modifier_mask;
      bus_attr_t  ref_attr;
   } attr_trig_t;

   // debug control write port
   typedef struct packed {
      logic        valid;
      logic [4:0]  index;
      logic [15:0] data;
   } dbg_write_t;

   // reserved modifier code for the given class
   function automatic logic attr_reserved(input bus_attr_t a);
      logic res;
      res = 1'b1;
      if (a.transfer_class == CLASS_NORMAL) begin
         res = !(a.transfer_modifier inside {MOD_LINE_PUSH, MOD_USER_DATA, MOD_USER_CODE,
                                            MOD_SUPER_DATA, MOD_SUPER_CODE});
      end else if (a.transfer_class == CLASS_EMULATOR) begin
         res = !(a.transfer_modifier inside {MOD_SUPER_DATA, MOD_SUPER_CODE});
      end
      if (a.width_code == 2'h3) begin
         res = 1'b1;
      end
      return res;
   endfunction

endpackage

// >>> verilog/attr_write_arbiter.sv
module attr_write_arbiter
   import attr_match_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // write sources
   input wire attr_match_pkg::dbg_write_t i_cpu_wr,
   input wire attr_match_pkg::dbg_write_t i_port_wr,
   // selected write
   output logic o_load,
   output logic [15:0] o_data
);
   import attr_match_pkg::*;

   // debug port wins a same-cycle collision: a halted core cannot issue one
   wire port_hit = i_port_wr.valid && (i_port_wr.index == ATTR_TRIG_INDEX);
   wire cpu_hit = i_cpu_wr.valid && (i_cpu_wr.index == ATTR_TRIG_INDEX);
   wire next_load = port_hit || cpu_hit;
   wire [15:0] next_data = port_hit ? i_port_wr.data : i_cpu_wr.data;

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_load <= 1'b0;
         o_data <= 16'h0000;
      end else begin
         o_load <= next_load;
         o_data <= next_data;
      end
   end
endmodule

// >>> verilog/attr_compare.sv
module attr_compare
   import attr_match_pkg::*;
(
   input wire attr_match_pkg::attr_trig_t i_trig,
   input wire attr_match_pkg::bus_attr_t i_bus,
   output logic o_match
);
   import attr_match_pkg::*;

   logic [7:0] care;
   logic [7:0] diff;

   // a set mask bit drops that bit from the compare
   assign care = ~{i_trig.direction_mask, i_trig.size_mask,
                   i_trig.transfer_class_mask, i_trig.transfer_modifier_mask};
   assign diff = i_trig.ref_attr ^ i_bus;
   assign o_match = ~|(diff & care);
endmodule

// >>> bench/bus_source.sv
module bus_source
   import attr_match_pkg::*;
(
   // clock
   input wire logic i_sys_clk,
   // request from bench
   input wire logic i_req,
   input wire attr_match_pkg::bus_attr_t i_attr,
   // local bus attributes
   output logic o_bus_valid,
   output attr_match_pkg::bus_attr_t o_bus_attr
);
   timeunit 1ns;
   timeprecision 1ns;
   bus_attr_t last = '0;
   // idle lines invert the last cycle so stale values never match by luck
   assign o_bus_valid = i_req;
   assign o_bus_attr = i_req ? i_attr : ~last;
   always @(posedge i_sys_clk) begin
      if (i_req) last <= i_attr;
   end
endmodule

// >>> bench/tb.sv
module tb
   import attr_match_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_sys_clk = 0, i_reset_n = 0, i_trig_attr_enable = 0, req = 0;
   dbg_write_t i_cpu_wr = '0, i_port_wr = '0;
   bus_attr_t req_attr = '0, i_bus_attr;
   logic i_bus_valid, o_attr_match, o_attr_reserved, o_cmd_ext_dma;
   logic [7:0] o_cmd_attr;
   logic [15:0] ref_reg = 16'h0005;
   int mismatches = 0, n_tests = 0;

   bus_source PTR (.i_sys_clk, .i_req(req), .i_attr(req_attr), .o_bus_valid(i_bus_valid),
      .o_bus_attr(i_bus_attr));
   attr_trigger_match DUT (.i_sys_clk, .i_reset_n, .i_cpu_wr, .i_port_wr, .i_bus_valid,
      .i_bus_attr, .i_trig_attr_enable, .o_attr_match, .o_attr_reserved, .o_cmd_attr,
      .o_cmd_ext_dma);

   initial forever #50 i_sys_clk = ~i_sys_clk;

   task automatic give_verdict();
      $display("counts: %0d tests %0d mismatches", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk_bit(input logic g, input logic e);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %0t bit got %b exp %b", $time, g, e);
      end
   endtask

   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %0t byte got %h exp %h", $time, g, e);
      end
   endtask

   task automatic check_cmd();
      logic [7:0] r;
      logic res;
      r = ref_reg[7:0];
      res = (r[6:5] == 2'h3) || r[3] || (r[4:3] == 2'h0 && r[2:0] inside {3'h3, 3'h4, 3'h7})
         || (r[4:3] == 2'h2 && !(r[2:0] inside {3'h5, 3'h6}));
      chk_byte(o_cmd_attr, r);
      chk_bit(o_cmd_ext_dma, r[4:3] == 2'h1);
      chk_bit(o_attr_reserved, res);
   endtask

   // src bit 0 cpu, bit 1 port; cpu carries the inverse so a lost collision shows
   task automatic wr(input logic [1:0] src, input logic [4:0] idx, input logic [15:0] d);
      @(negedge i_sys_clk);
      if (src[1]) i_port_wr <= '{1'b1, idx, d};
      if (src[0]) i_cpu_wr <= '{1'b1, idx, src[1] ? ~d : d};
      @(negedge i_sys_clk);
      i_port_wr.valid <= 1'b0;
      i_cpu_wr.valid <= 1'b0;
      repeat (3) @(negedge i_sys_clk);
      if (idx == ATTR_TRIG_INDEX) ref_reg = d;
      check_cmd();
   endtask

   task automatic bus(input logic v, input logic en, input bus_attr_t a);
      logic e;
      @(negedge i_sys_clk);
      req <= v;
      req_attr <= a;
      i_trig_attr_enable <= en;
      e = v && en && (((ref_reg[7:0] ^ a) & ~ref_reg[15:8]) == 8'h00);
      @(negedge i_sys_clk);
      chk_bit(o_attr_match, e);
      req <= 1'b0;
   endtask

   initial begin
      #3_000_000;
      mismatches++;
      give_verdict();
   end

   initial begin
      void'($urandom(8));
      repeat (10) @(negedge i_sys_clk);
      i_reset_n <= 1'b1;
      check_cmd();
      bus(1, 1, 8'h05);
      bus(1, 1, 8'h85);
      $display("test reset done");
      for (int k = 0; k < 128; k++) begin
         wr({1'b0, 1'b1} << k[0], ATTR_TRIG_INDEX, {8'h00, 1'b1, k[6:0]});
         bus(1, 1, {1'b1, k[6:0]});
         bus(1, 1, {1'b0, k[6:0]});
      end
      $display("test code table done");
      wr(2'h1, TRIG_DEF_INDEX, 16'hffff);
      wr(2'h2, 5'h05, 16'h00ff);
      wr(2'h3, ATTR_TRIG_INDEX, 16'h0095);
      $display("test index and collision done");
      for (int n = 0; n < 300; n++) begin
         wr(2'(1 + $urandom % 3), ATTR_TRIG_INDEX, 16'($urandom));
         repeat (4) bus($urandom % 4 != 0, $urandom % 4 != 0,
            ref_reg[7:0] ^ (8'($urandom) & 8'($urandom) & 8'($urandom)));
      end
      $display("test random masks done");
      @(negedge i_sys_clk);
      i_reset_n <= 1'b0;
      repeat (2) @(negedge i_sys_clk);
      i_reset_n <= 1'b1;
      ref_reg = 16'h0005;
      @(negedge i_sys_clk);
      check_cmd();
      bus(1, 1, 8'h05);
      $display("test second reset done");
      give_verdict();
   end
endmodule
